// File: scss_pkg.sv
// Package for the system clock source select block.
// Assumes one 40 MHz sampling clock and 8-bit registers.
package scss_pkg;
    localparam int          CLK_MHZ        = 40;
    localparam int          ADDR_W         = 3;
    localparam int          DATA_W         = 8;
    // Register offsets
    localparam logic [2:0]  SYS_CLOCK_CTRL_REG_OFS     = 3'h0;
    localparam logic [2:0]  INTERNAL_FAST_CTRL_REG_OFS = 3'h1;
    localparam logic [2:0]  FAST_XTAL_CTRL_REG_OFS     = 3'h2;
    localparam logic [2:0]  SLOW_XTAL_CTRL_REG_OFS     = 3'h3;
    localparam logic [2:0]  PIN_SHARE_CTRL_REG_OFS     = 3'h4;
    // Field positions
    localparam int          SCC_CKS_LSB    = 5;
    localparam int          SCC_FHS_BIT    = 3;
    localparam int          SCC_FSS_BIT    = 2;
    localparam int          SCC_FHIDEN_BIT = 1;
    localparam int          SCC_FSIDEN_BIT = 0;
    localparam int          FRQ_SEL_LSB    = 2;
    localparam int          MODE_BIT       = 2;
    localparam int          FLAG_BIT       = 1;
    localparam int          EN_BIT         = 0;
    localparam int          PIN_OSC_BIT    = 0;
    // Reset values
    localparam logic [7:0]  SCC_RST        = 8'h00;
    localparam logic [7:0]  INTERNAL_FAST_CTRL_REG_RST      = 8'h01;
    localparam logic [7:0]  HXTC_RST       = 8'h00;
    localparam logic [7:0]  LXTC_RST       = 8'h00;
    localparam logic [7:0]  PIN_RST        = 8'h00;
    // System clock select codes
    localparam logic [2:0]  CKS_FAST       = 3'h0;
    localparam logic [2:0]  CKS_SUB        = 3'h7;
    // Internal fast RC frequency codes
    localparam logic [1:0]  FRQ_8MHZ       = 2'h0;
    localparam logic [1:0]  FRQ_12MHZ      = 2'h1;
    localparam logic [1:0]  FRQ_16MHZ      = 2'h2;
    localparam logic [1:0]  FRQ_8MHZ_ALT   = 2'h3;
    // Switch delay: current system clock periods before the swap
    localparam logic [2:0]  SWITCH_SYS_PERIODS = 3'h4;
    // Source edges counted before an oscillator is trusted
    localparam int          STB_W          = 12;
    localparam logic [11:0] FAST_RC_OSC_STB_EDGES = 12'h010;
    localparam logic [11:0] HXT_STB_EDGES  = 12'h100;
    localparam logic [11:0] LXT_STB_EDGES  = 12'h400;
endpackage

// File: scss_top.sv
// System clock source select, fast clock divider and oscillator control.
// Assumes oscillator outputs arrive as asynchronous levels sampled by clock,
// which must run well above twice the fastest oscillator.
// Operation
// - Fast clock: crystal or RC by select
// - Sub clock: crystal or RC by select
// - Three-bit field picks system clock source
// - Fast clock divided by 2 up to 64
// - Fast RC runs 8/12/16 MHz per option
// - Slow crystal enable starts it, wait start-up
// - Fast oscillator in slow mode follows enable
// - Running fast clocks stay for peripherals
// - Halt gates CPU clock, timer clock continues only with wdt_enable, FSIDEN set or slow RC as sub source
// - Pin bits give slow crystal pins' function
// - Codes 000 fast, 001-110 divided, 111 sub
// - Fast select 0 RC, 1 crystal
// - Slow select 0 RC, 1 crystal
// - Switch waits four system periods plus alignment
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps

module scss_stable #(
    parameter logic [11:0] EDGES = 12'h010
) (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        run,
    input  wire logic        rise,
    output logic             stable_ff
);
    import scss_pkg::*;
    logic [STB_W-1:0] cnt_ff;

    // Counting real source edges, not time, proves the oscillator runs
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_ff    <= '0;
            stable_ff <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_ff    <= '0;
                stable_ff <= 1'b0;
            end else if (rise && !stable_ff) begin
                cnt_ff    <= cnt_ff + 12'h001;
                stable_ff <= (cnt_ff + 12'h001 >= EDGES);
            end
        end
    end
endmodule

module scss_switch #(
    parameter int SW = 1
) (
    input  wire logic                 clock,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    input  wire logic [(1<<SW)-1:0]   lvl,
    input  wire logic [SW-1:0]        want,
    input  wire logic                 ready,
    input  wire logic                 sys_rise,
    output logic      [SW-1:0]        sel_ff,
    output logic                      out_ff
);
    import scss_pkg::*;
    logic [2:0] wait_ff;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_ff <= 3'h0;
        end else if (ce) begin
            if (want == sel_ff || !ready) begin
                wait_ff <= 3'h0;
            end else if (sys_rise && wait_ff != SWITCH_SYS_PERIODS) begin
                wait_ff <= wait_ff + 3'h1;
            end
        end
    end

    // Swap after a low output cycle with old and new low: no runt either way
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sel_ff <= '0;
        end else if (ce) begin
            if (want != sel_ff && ready && wait_ff == SWITCH_SYS_PERIODS
                    && !out_ff && !lvl[sel_ff] && !lvl[want]) begin
                sel_ff <= want;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out_ff <= 1'b0;
        end else if (ce) begin
            out_ff <= lvl[sel_ff];
        end
    end
endmodule

module scss_top (
    input  wire logic                           clock,
    input  wire logic                           resetn,
    input  wire logic                           ce,
    input  wire logic [scss_pkg::ADDR_W-1:0]    addr,
    input  wire logic [scss_pkg::DATA_W-1:0]    wdata,
    input  wire logic                           wr,
    input  wire logic                           rd,
    output logic      [scss_pkg::DATA_W-1:0]    rdata,
    input  wire logic                           fast_crystal_osc,
    input  wire logic                           fast_rc_osc,
    input  wire logic                           slow_crystal_osc,
    input  wire logic                           slow_rc_osc,
    input  wire logic [1:0]                     cfg_fast_rc_freq,
    input  wire logic                           halt,
    input  wire logic                           wdt_enable,
    output logic                                fast_crystal_en,
    output logic                                fast_crystal_mode,
    output logic                                fast_rc_en,
    output logic      [1:0]                     fast_rc_freq,
    output logic      [1:0]                     fast_rc_trim,
    output logic                                slow_crystal_en,
    output logic                                slow_crystal_speedup,
    output logic                                slow_rc_en,
    output logic                                slow_crystal_pins_osc,
    output logic                                sys_clk,
    output logic                                cpu_clk,
    output logic                                fast_periph_clk,
    output logic      [5:0]                     fast_div_clk,
    output logic                                sub_periph_clk,
    output logic                                timer_clk
);
    import scss_pkg::*;

    logic [7:0] scc_ff;
    logic [7:0] internal_fast_ctrl_reg_ff;
    logic [7:0] hxtc_ff;
    logic [7:0] lxtc_ff;
    logic [7:0] pin_ff;
    logic [7:0] rdata_ff;
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    logic [3:0] prev_ff;
    logic [3:0] rise;
    logic       fast_rc_osc_st;
    logic       hxt_st;
    logic       lxt_st;
    logic       slow_rc_osc_st;
    logic       fast_lvl;
    logic       sub_lvl;
    logic       sys_lvl;
    logic       fast_prev_ff;
    logic       sys_prev_ff;
    logic [5:0] div_ff;
    logic       fast_rdy;
    logic       sub_rdy;
    logic       sys_rdy;
    logic       fast_need;
    logic       sub_need;
    logic       hold_fast;
    logic       hold_sub;
    logic       rc_run_ff;
    logic       xt_run_ff;
    logic       lxt_run_ff;
    logic       slow_rc_osc_run_ff;
    logic [1:0] freq_ff;
    logic       cpu_ff;
    logic       fper_ff;
    logic       sper_ff;
    logic       tmr_ff;
    logic [7:0] sys_lvls;
    logic       sys_rise;

    // Oscillators and the option strap are foreign to clock
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else if (ce) begin
            sync1_ff <= {cfg_fast_rc_freq, slow_rc_osc, slow_crystal_osc, fast_rc_osc, fast_crystal_osc};
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            prev_ff <= '0;
        end else if (ce) begin
            prev_ff <= sync2_ff[3:0];
        end
    end
    assign rise = sync2_ff[3:0] & ~prev_ff;

    // Register writes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scc_ff   <= SCC_RST;
            internal_fast_ctrl_reg_ff <= INTERNAL_FAST_CTRL_REG_RST;
            hxtc_ff  <= HXTC_RST;
            lxtc_ff  <= LXTC_RST;
            pin_ff   <= PIN_RST;
        end else if (ce && wr) begin
            case (addr)
                SYS_CLOCK_CTRL_REG_OFS:     scc_ff   <= wdata & 8'hef;
                INTERNAL_FAST_CTRL_REG_OFS: internal_fast_ctrl_reg_ff <= wdata & 8'h0d;
                FAST_XTAL_CTRL_REG_OFS:     hxtc_ff  <= wdata & 8'h05;
                SLOW_XTAL_CTRL_REG_OFS:     lxtc_ff  <= wdata & 8'h05;
                PIN_SHARE_CTRL_REG_OFS:     pin_ff   <= wdata & 8'h01;
                default: begin
                end
            endcase
        end
    end

    // Reads show live stable flags; unmapped offsets read zero
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 8'h00;
        end else if (ce) begin
            if (rd) begin
                case (addr)
                    SYS_CLOCK_CTRL_REG_OFS:     rdata_ff <= scc_ff;
                    INTERNAL_FAST_CTRL_REG_OFS: rdata_ff <= internal_fast_ctrl_reg_ff | {6'h00, fast_rc_osc_st, 1'b0};
                    FAST_XTAL_CTRL_REG_OFS:     rdata_ff <= hxtc_ff | {6'h00, hxt_st, 1'b0};
                    SLOW_XTAL_CTRL_REG_OFS:     rdata_ff <= lxtc_ff | {6'h00, lxt_st, 1'b0};
                    PIN_SHARE_CTRL_REG_OFS:     rdata_ff <= pin_ff;
                    default:                    rdata_ff <= 8'h00;
                endcase
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    // Oscillator run control
    assign fast_need = (!halt && scc_ff[7:5] != CKS_SUB) || (halt && scc_ff[SCC_FHIDEN_BIT]);
    assign sub_need  = !halt || scc_ff[SCC_FSIDEN_BIT];
    assign hold_fast = halt && !scc_ff[SCC_FHIDEN_BIT];
    assign hold_sub  = halt && !scc_ff[SCC_FSIDEN_BIT];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rc_run_ff   <= 1'b1;
            xt_run_ff   <= 1'b0;
            lxt_run_ff  <= 1'b0;
            slow_rc_osc_run_ff <= 1'b1;
        end else if (ce) begin
            // In slow mode the fast oscillator runs only if its enable is set
            rc_run_ff   <= ((fast_need && !scc_ff[SCC_FHS_BIT]) || internal_fast_ctrl_reg_ff[EN_BIT]) && !hold_fast;
            xt_run_ff   <= ((fast_need && scc_ff[SCC_FHS_BIT]) || hxtc_ff[EN_BIT]) && !hold_fast;
            lxt_run_ff  <= ((sub_need && scc_ff[SCC_FSS_BIT]) || lxtc_ff[EN_BIT]) && !hold_sub;
            slow_rc_osc_run_ff <= !hold_sub || wdt_enable || !scc_ff[SCC_FSS_BIT];
        end
    end

    scss_stable #(.EDGES(HXT_STB_EDGES)) u_hxt_st (
        .clock(clock), .resetn(resetn), .ce(ce), .run(xt_run_ff), .rise(rise[0]), .stable_ff(hxt_st));
    scss_stable #(.EDGES(FAST_RC_OSC_STB_EDGES)) u_fast_rc_osc_st (
        .clock(clock), .resetn(resetn), .ce(ce), .run(rc_run_ff), .rise(rise[1]), .stable_ff(fast_rc_osc_st));
    scss_stable #(.EDGES(LXT_STB_EDGES)) u_lxt_st (
        .clock(clock), .resetn(resetn), .ce(ce), .run(lxt_run_ff), .rise(rise[2]), .stable_ff(lxt_st));
    scss_stable #(.EDGES(FAST_RC_OSC_STB_EDGES)) u_slow_rc_osc_st (
        .clock(clock), .resetn(resetn), .ce(ce), .run(slow_rc_osc_run_ff), .rise(rise[3]), .stable_ff(slow_rc_osc_st));

    // Fast clock source: 0 RC, 1 crystal
    assign fast_rdy = scc_ff[SCC_FHS_BIT] ? hxt_st : fast_rc_osc_st;
    scss_switch #(.SW(1)) u_fast_sw (
        .clock    (clock),
        .resetn   (resetn),
        .ce       (ce),
        .lvl      ({sync2_ff[0], sync2_ff[1]}),
        .want     (scc_ff[SCC_FHS_BIT]),
        .ready    (fast_rdy),
        .sys_rise (sys_rise),
        .sel_ff   (),
        .out_ff   (fast_lvl)
    );

    // Sub clock source: 0 RC, 1 crystal
    assign sub_rdy = scc_ff[SCC_FSS_BIT] ? lxt_st : slow_rc_osc_st;
    scss_switch #(.SW(1)) u_sub_sw (
        .clock    (clock),
        .resetn   (resetn),
        .ce       (ce),
        .lvl      ({sync2_ff[2], sync2_ff[3]}),
        .want     (scc_ff[SCC_FSS_BIT]),
        .ready    (sub_rdy),
        .sys_rise (sys_rise),
        .sel_ff   (),
        .out_ff   (sub_lvl)
    );

    // Ripple of the fast clock: bit n is fast clock divided by 2^(n+1)
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fast_prev_ff <= 1'b0;
            div_ff       <= '0;
        end else if (ce) begin
            fast_prev_ff <= fast_lvl;
            if (fast_lvl && !fast_prev_ff) begin
                div_ff <= div_ff + 6'h01;
            end
        end
    end

    // Candidate levels indexed by the select code
    assign sys_lvls = {sub_lvl, div_ff, fast_lvl};
    assign sys_rdy  = (scc_ff[7:5] == CKS_SUB) ? sub_rdy : fast_rdy;
    scss_switch #(.SW(3)) u_sys_sw (
        .clock    (clock),
        .resetn   (resetn),
        .ce       (ce),
        .lvl      (sys_lvls),
        .want     (scc_ff[7:5]),
        .ready    (sys_rdy),
        .sys_rise (sys_rise),
        .sel_ff   (),
        .out_ff   (sys_lvl)
    );

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sys_prev_ff <= 1'b0;
        end else if (ce) begin
            sys_prev_ff <= sys_lvl;
        end
    end
    assign sys_rise = sys_lvl && !sys_prev_ff;

    // Gated and peripheral clocks
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cpu_ff  <= 1'b0;
            fper_ff <= 1'b0;
            sper_ff <= 1'b0;
            tmr_ff  <= 1'b0;
            freq_ff <= FRQ_8MHZ;
        end else if (ce) begin
            cpu_ff  <= sys_lvl && !halt;
            fper_ff <= fast_lvl && !hold_fast;
            sper_ff <= sub_lvl && !hold_sub;
            tmr_ff  <= sync2_ff[3] && slow_rc_osc_run_ff;
            // Code 11 is a duplicate of 8 MHz
            freq_ff <= (sync2_ff[5:4] == FRQ_8MHZ_ALT) ? FRQ_8MHZ : sync2_ff[5:4];
        end
    end

    assign rdata                 = rdata_ff;
    assign fast_crystal_en       = xt_run_ff;
    assign fast_crystal_mode     = hxtc_ff[MODE_BIT];
    assign fast_rc_en            = rc_run_ff;
    assign fast_rc_freq          = freq_ff;
    assign fast_rc_trim          = internal_fast_ctrl_reg_ff[FRQ_SEL_LSB+1:FRQ_SEL_LSB];
    assign slow_crystal_en       = lxt_run_ff;
    assign slow_crystal_speedup  = lxtc_ff[MODE_BIT];
    assign slow_rc_en            = slow_rc_osc_run_ff;
    assign slow_crystal_pins_osc = pin_ff[PIN_OSC_BIT];
    assign sys_clk               = sys_lvl;
    assign cpu_clk               = cpu_ff;
    assign fast_periph_clk       = fper_ff;
    assign fast_div_clk          = div_ff;
    assign sub_periph_clk        = sper_ff;
    assign timer_clk             = tmr_ff;
endmodule

// File: scss_osc_model.sv
// Behavioural oscillator source standing at the block's oscillator inputs.
// Assumes its enable comes from the block's run enable for that source.
`timescale 1ns/100ps
module scss_osc_model #(
    parameter int HALF = 55
) (
    input  wire logic en,
    output logic      osc
);
    // Stopped source stands still low, never free runs
    always begin
        if (en === 1'b1) begin
            osc = (osc === 1'b1);
            #(HALF) osc = !osc;
        end else begin
            osc = 1'b0;
            @(en);
        end
    end
endmodule

// File: scss_top_properties.sv
// Port-level checks for the clock select block.
// Assumes bound to scss_top with oscillators slower than a quarter of clock.
`timescale 1ns/100ps
module scss_top_properties
    import scss_pkg::*;
(
    input wire logic                        clock,
    input wire logic                        resetn,
    input wire logic                        ce,
    input wire logic [scss_pkg::ADDR_W-1:0] addr,
    input wire logic [scss_pkg::DATA_W-1:0] wdata,
    input wire logic                        wr,
    input wire logic                        rd,
    input wire logic [1:0]                  cfg_fast_rc_freq,
    input wire logic                        halt,
    input wire logic                        wdt_enable,
    input wire logic [1:0]                  fast_rc_freq,
    input wire logic [1:0]                  fast_rc_trim,
    input wire logic                        slow_crystal_en,
    input wire logic                        slow_rc_en,
    input wire logic                        slow_crystal_pins_osc,
    input wire logic                        sys_clk,
    input wire logic                        cpu_clk,
    input wire logic [5:0]                  fast_div_clk,
    input wire logic                        timer_clk
);
    logic [2:0] up_ff;
    logic [2:0] nxt_up;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Strap sync pipe is not trusted until a few cycles after reset
    assign nxt_up = (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            up_ff <= 3'h0;
        end else begin
            up_ff <= nxt_up;
        end
    end
    rc_freq_map_a: assert property ((up_ff == 3'h7) ##0 $stable(cfg_fast_rc_freq) [*5] |->
        fast_rc_freq == ((cfg_fast_rc_freq == 2'h3) ? 2'h0 : cfg_fast_rc_freq)) else $error("rc freq map");
    trim_field_a: assert property (ce && wr && addr == INTERNAL_FAST_CTRL_REG_OFS |=>
        fast_rc_trim == $past(wdata[3:2])) else $error("trim field");
    lxt_start_a: assert property (ce && wr && addr == SLOW_XTAL_CTRL_REG_OFS && wdata[EN_BIT] && !halt ##1 !halt
        |=> slow_crystal_en) else $error("slow crystal start");
    pins_osc_a: assert property (ce && wr && addr == PIN_SHARE_CTRL_REG_OFS |=>
        slow_crystal_pins_osc == $past(wdata[PIN_OSC_BIT])) else $error("pin share");
    cpu_gate_a: assert property (halt |=> !cpu_clk) else $error("cpu clock not gated");
    cpu_follow_a: assert property (!halt && sys_clk |=> cpu_clk) else $error("cpu clock lost");
    timer_rc_on_a: assert property (wdt_enable [*3] |-> slow_rc_en) else $error("timer source off");
    sys_runt_hi_a: assert property ($rose(sys_clk) |=> sys_clk) else $error("sys high runt");
    sys_runt_lo_a: assert property ($fell(sys_clk) |=> !sys_clk) else $error("sys low runt");
    div_runt_a: assert property ($rose(fast_div_clk[0]) |=> fast_div_clk[0] [*2]) else $error("div runt");
    cover property (halt && timer_clk);
    cover property ($rose(slow_crystal_en));
    cover property (rd && addr > 3'h4);
endmodule
bind scss_top scss_top_properties u_scss_top_properties (.*);

// File: system_clock_source_select_tb.sv
// Self-checking bench for the clock select block with behavioural oscillators.
// Assumes oscillator models far slower than clock, so counts carry a tolerance.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e); end end
module system_clock_source_select_tb;
    import scss_pkg::*;
    localparam int WIN = 1600;
    localparam int SETTLE = 1500;
    localparam int HXT_H = 55;
    localparam int FAST_RC_OSC_H = 85;
    localparam int LXT_H = 260;
    localparam int SLOW_RC_OSC_H = 410;
    logic              clock, resetn, ce, wr, rd, halt, wdt_enable, quiet, pend;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [1:0]        cfg_fast_rc_freq, fast_rc_freq, fast_rc_trim;
    logic [5:0]        fast_div_clk;
    logic              fast_crystal_osc, fast_rc_osc, slow_crystal_osc, slow_rc_osc;
    logic              fast_crystal_en, fast_crystal_mode, fast_rc_en, slow_crystal_en, slow_crystal_speedup;
    logic              slow_rc_en, slow_crystal_pins_osc, sys_clk, cpu_clk, fast_periph_clk, sub_periph_clk, timer_clk;
    logic [31:0]       lfsr_ff;
    logic [15:0]       exp_q [$];
    int                cnt [11];
    int                error_cnt, num_checks;
    logic [7:0]        rst_v [8] = '{SCC_RST, INTERNAL_FAST_CTRL_REG_RST, HXTC_RST, LXTC_RST, PIN_RST, 8'h00, 8'h00, 8'h00};
    logic [7:0]        keep_v [8] = '{8'hef, 8'h0d, 8'h05, 8'h05, 8'h01, 8'h00, 8'h00, 8'h00};
    logic [7:0]        mask_v [8] = '{8'hef, 8'h0d, 8'h05, 8'h05, 8'h01, 8'hff, 8'hff, 8'hff};

    scss_top u_scss_top (.*);
    scss_osc_model #(.HALF(HXT_H)) u_hxt (.en(fast_crystal_en), .osc(fast_crystal_osc));
    scss_osc_model #(.HALF(FAST_RC_OSC_H)) u_fast_rc_osc (.en(fast_rc_en), .osc(fast_rc_osc));
    scss_osc_model #(.HALF(LXT_H)) u_lxt (.en(slow_crystal_en), .osc(slow_crystal_osc));
    scss_osc_model #(.HALF(SLOW_RC_OSC_H)) u_slow_rc_osc (.en(slow_rc_en), .osc(slow_rc_osc));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Edge counts over the window, from a source half period and a divide shift
    function automatic int ec(input int half, input int sh);
        return (WIN * 25) / ((2 * half) << sh);
    endfunction
    // Sampling phase is unrelated to the sources, so allow a few edges either way
    function automatic logic near(input int c, input int e);
        return (c >= e - 3) && (c <= e + 3);
    endfunction

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back({m, e});
        @(posedge clock);
        rd <= 1'b0;
    endtask
    task automatic wait_flag(input logic [2:0] a);
        logic ok;
        int   tries;
        ok = 1'b0;
        tries = 0;
        quiet = 1'b1;
        while (!ok && tries < 300) begin
            @(posedge clock);
            addr <= a;
            rd <= 1'b1;
            @(posedge clock);
            rd <= 1'b0;
            @(negedge clock);
            ok = (rdata[FLAG_BIT] === 1'b1);
            tries++;
            repeat (100) @(posedge clock);
        end
        quiet = 1'b0;
        `CHK(ok, 1'b1)
    endtask
    task automatic measure();
        logic [10:0] prv, cur;
        prv = '0;
        foreach (cnt[i]) cnt[i] = 0;
        repeat (WIN) begin
            @(posedge clock);
            cur = {sub_periph_clk, fast_div_clk, fast_periph_clk, timer_clk, cpu_clk, sys_clk};
            for (int i = 0; i < 11; i++) if (cur[i] && !prv[i]) cnt[i]++;
            prv = cur;
        end
    endtask
    task automatic wr_meas(input logic [2:0] a, input logic [7:0] d);
        wr_reg(a, d);
        repeat (SETTLE) @(posedge clock);
        measure();
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        logic [15:0] e;
        if (pend === 1'b1) begin
            e = exp_q.pop_front();
            `CHK(rdata & e[15:8], e[7:0] & e[15:8])
        end
        pend <= rd & !quiet;
    end

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        #(25 * 95000);
        error_cnt++;
        summarize();
    end

    initial begin
        logic [7:0] d;
        {resetn, wr, rd, halt, wdt_enable, quiet, pend} = '0;
        ce = 1'b1;
        addr = '0;
        wdata = '0;
        cfg_fast_rc_freq = FRQ_8MHZ;
        lfsr_ff = 32'h8e46;
        error_cnt = 0;
        num_checks = 0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        for (int a = 0; a < 8; a++) rd_reg(3'(a), rst_v[a], 8'hff);
        for (int c = 0; c < 4; c++) begin
            @(posedge clock);
            cfg_fast_rc_freq <= 2'(c);
            repeat (8) @(posedge clock);
            `CHK(fast_rc_freq, (c == 3) ? FRQ_8MHZ : 2'(c))
        end
        cfg_fast_rc_freq <= FRQ_16MHZ;
        // Random data never touches the live source selection or the running RC
        for (int a = 0; a < 8; a++) begin
            lfsr_ff = lfsr_next(lfsr_ff);
            d = lfsr_ff[7:0];
            d = (a == 0) ? (d & 8'h07) : (a == 1) ? (d | 8'h01) : d;
            wr_reg(3'(a), d);
            rd_reg(3'(a), d & keep_v[a], mask_v[a]);
        end
        wr_reg(INTERNAL_FAST_CTRL_REG_OFS, 8'h09);
        @(negedge clock);
        `CHK(fast_rc_trim, FRQ_16MHZ)
        wr_reg(FAST_XTAL_CTRL_REG_OFS, 8'h00);
        wr_reg(SLOW_XTAL_CTRL_REG_OFS, 8'h00);
        wr_reg(PIN_SHARE_CTRL_REG_OFS, 8'h01);
        @(negedge clock);
        `CHK(slow_crystal_pins_osc, 1'b1)
        wr_reg(FAST_XTAL_CTRL_REG_OFS, 8'h05);
        wait_flag(FAST_XTAL_CTRL_REG_OFS);
        `CHK(fast_crystal_mode, 1'b1)
        wr_meas(SYS_CLOCK_CTRL_REG_OFS, 8'h08);
        `CHK(near(cnt[0], ec(HXT_H, 0)), 1'b1)
        for (int k = 0; k < 7; k++) begin
            wr_meas(SYS_CLOCK_CTRL_REG_OFS, 8'(k << SCC_CKS_LSB));
            `CHK(near(cnt[0], ec(FAST_RC_OSC_H, k)), 1'b1)
            if (k < 6) `CHK(near(cnt[4 + k], ec(FAST_RC_OSC_H, k + 1)), 1'b1)
        end
        // Leaving divide by 64 is the slowest switch of all
        wr_reg(SYS_CLOCK_CTRL_REG_OFS, 8'h00);
        repeat (2800) @(posedge clock);
        wr_meas(SYS_CLOCK_CTRL_REG_OFS, 8'he0);
        `CHK(near(cnt[0], ec(SLOW_RC_OSC_H, 0)), 1'b1)
        `CHK(near(cnt[3], ec(FAST_RC_OSC_H, 0)), 1'b1)
        `CHK(near(cnt[10], ec(SLOW_RC_OSC_H, 0)), 1'b1)
        wr_reg(SLOW_XTAL_CTRL_REG_OFS, 8'h05);
        wr_meas(SYS_CLOCK_CTRL_REG_OFS, 8'he4);
        `CHK(near(cnt[0], ec(SLOW_RC_OSC_H, 0)), 1'b1)
        wait_flag(SLOW_XTAL_CTRL_REG_OFS);
        `CHK(slow_crystal_speedup, 1'b1)
        wr_meas(SYS_CLOCK_CTRL_REG_OFS, 8'he4);
        `CHK(near(cnt[0], ec(LXT_H, 0)), 1'b1)
        wr_meas(INTERNAL_FAST_CTRL_REG_OFS, 8'h08);
        `CHK(fast_rc_en, 1'b0)
        `CHK(near(cnt[3], 0), 1'b1)
        @(posedge clock);
        halt <= 1'b1;
        repeat (SETTLE) @(posedge clock);
        measure();
        `CHK(near(cnt[1], 0), 1'b1)
        `CHK(near(cnt[2], 0), 1'b1)
        `CHK(near(cnt[10], 0), 1'b1)
        @(posedge clock);
        wdt_enable <= 1'b1;
        repeat (SETTLE) @(posedge clock);
        measure();
        `CHK(near(cnt[2], ec(SLOW_RC_OSC_H, 0)), 1'b1)
        @(posedge clock);
        halt <= 1'b0;
        summarize();
    end
endmodule
